//--- hw/serie_pkg.sv
// Constants for the serializer interrupt enable and status logic.
// Assumes an 8-bit register port addressed by the serial control bus.
package serie_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int NUM_EVT = 7;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hC6;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hC7;
    localparam logic [7:0] RESET_IRQ_ENABLE = 8'h00;
    localparam int BIT_INDIRECT_DONE = 7;
    localparam int BIT_RX_DETECT = 6;
    localparam int BIT_DOWNSTREAM_IRQ = 5;
    localparam int BIT_KEY_LIST_RDY = 4;
    localparam int BIT_RX_KEY_RDY = 3;
    localparam int BIT_AUTH_FAIL = 2;
    localparam int BIT_AUTH_PASS = 1;
    localparam int BIT_GLOBAL = 0;
endpackage

//--- hw/serie_event_latch.sv
// Sticky latches for the seven interrupt events.
// Assumes event inputs are synchronous one-cycle pulses or levels.
module serie_event_latch #(
    parameter int N = 7
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [N-1:0] evt,
    input wire logic [N-1:0] clr,
    output logic [N-1:0] flags
);
    typedef struct packed {
        logic [N-1:0] flags;
    } serie_latch_t;

    serie_latch_t s_q;
    serie_latch_t s_d;

    // ==========================================================
    // Set wins over clear
    always_comb begin
        s_d = s_q;
        s_d.flags = (s_q.flags & ~clr) | evt;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flags = s_q.flags;
endmodule

//--- hw/serie_top.sv
// Interrupt enable control and status registers of the serializer.
// Assumes a simple synchronous register port: write strobe, read strobe.
module serie_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [serie_pkg::ADDR_W-1:0] ADDR,
    input wire logic WR_EN,
    input wire logic [serie_pkg::DATA_W-1:0] WDATA,
    input wire logic RD_EN,
    output logic [serie_pkg::DATA_W-1:0] RDATA,
    input wire logic INDIRECT_DONE,
    input wire logic RX_DETECT,
    input wire logic DOWNSTREAM_IRQ,
    input wire logic KEY_LIST_READY,
    input wire logic RX_KEY_READY,
    input wire logic AUTH_FAIL,
    input wire logic AUTH_PASS,
    output logic IRQ
);
    // ==========================================================
    // Sizes shared with the package
    localparam int NE = serie_pkg::NUM_EVT;
    localparam int DW = serie_pkg::DATA_W;
    localparam int AW = serie_pkg::ADDR_W;

    // ==========================================================
    // Registered state: enable byte, read data, interrupt line
    typedef struct packed {
        logic [DW-1:0] enable;
        logic [DW-1:0] rdata;
        logic irq;
    } serie_state_t;

    serie_state_t s_q;
    serie_state_t s_d;

    // ==========================================================
    // Event side
    logic [NE-1:0] evt;
    logic [NE-1:0] flags;
    logic [NE-1:0] clr;
    logic [NE-1:0] evt_en;
    logic [NE-1:0] gated;
    logic [DW-1:0] status;
    logic global_int;

    // Register side
    logic wr_enable;
    logic rd_status;

    // Named fields of the enable register
    logic irq_master_en;
    logic indirect_access_done_irq_en;
    logic receiver_detect_irq_en;
    logic downstream_irq_forward_en;
    logic key_list_ready_irq_en;
    logic receiver_key_ready_irq_en;
    logic auth_failure_irq_en;
    logic auth_pass_irq_en;

    // ==========================================================
    // Address decode helper
    function automatic logic addr_hit(
        input logic [AW-1:0] addr,
        input logic [AW-1:0] target
    );
        return addr == target;
    endfunction

    // ==========================================================
    // Status and read helpers
    // Flags above, global bit at bit 0
    function automatic logic [DW-1:0] pack_status(
        input logic [NE-1:0] f,
        input logic g
    );
        return {f, g};
    endfunction

    // Unmapped addresses read as zero
    function automatic logic [DW-1:0] read_value(
        input logic [AW-1:0] addr,
        input logic [DW-1:0] en,
        input logic [DW-1:0] st
    );
        logic [DW-1:0] v;
        unique case (addr)
            serie_pkg::ADDR_IRQ_ENABLE: v = en;
            serie_pkg::ADDR_IRQ_STATUS: v = st;
            default: v = '0;
        endcase
        return v;
    endfunction

    // ==========================================================
    // Event inputs, index = register bit minus one
    always_comb begin
        evt = '0;
        evt[serie_pkg::BIT_INDIRECT_DONE-1] = INDIRECT_DONE;
        evt[serie_pkg::BIT_RX_DETECT-1] = RX_DETECT;
        evt[serie_pkg::BIT_DOWNSTREAM_IRQ-1] = DOWNSTREAM_IRQ;
        evt[serie_pkg::BIT_KEY_LIST_RDY-1] = KEY_LIST_READY;
        evt[serie_pkg::BIT_RX_KEY_RDY-1] = RX_KEY_READY;
        evt[serie_pkg::BIT_AUTH_FAIL-1] = AUTH_FAIL;
        evt[serie_pkg::BIT_AUTH_PASS-1] = AUTH_PASS;
    end

    // ==========================================================
    // Register decode
    assign wr_enable = WR_EN && addr_hit(ADDR, serie_pkg::ADDR_IRQ_ENABLE);
    assign rd_status = RD_EN && addr_hit(ADDR, serie_pkg::ADDR_IRQ_STATUS);

    // ==========================================================
    // Sticky flags; a status read clears only what it showed
    assign clr = rd_status ? flags : '0;

    serie_event_latch #(
        .N(NE)
    ) u_latch (
        .clk(CLK),
        .rst(RST),
        .evt(evt),
        .clr(clr),
        .flags(flags)
    );

    // ==========================================================
    // Enable fields
    assign irq_master_en = s_q.enable[serie_pkg::BIT_GLOBAL];
    assign indirect_access_done_irq_en =
        s_q.enable[serie_pkg::BIT_INDIRECT_DONE];
    assign receiver_detect_irq_en =
        s_q.enable[serie_pkg::BIT_RX_DETECT];
    assign downstream_irq_forward_en =
        s_q.enable[serie_pkg::BIT_DOWNSTREAM_IRQ];
    assign key_list_ready_irq_en =
        s_q.enable[serie_pkg::BIT_KEY_LIST_RDY];
    assign receiver_key_ready_irq_en =
        s_q.enable[serie_pkg::BIT_RX_KEY_RDY];
    assign auth_failure_irq_en =
        s_q.enable[serie_pkg::BIT_AUTH_FAIL];
    assign auth_pass_irq_en =
        s_q.enable[serie_pkg::BIT_AUTH_PASS];

    // Enables lined up with the event vector
    always_comb begin
        evt_en = '0;
        evt_en[serie_pkg::BIT_INDIRECT_DONE-1] =
            indirect_access_done_irq_en;
        evt_en[serie_pkg::BIT_RX_DETECT-1] =
            receiver_detect_irq_en;
        evt_en[serie_pkg::BIT_DOWNSTREAM_IRQ-1] =
            downstream_irq_forward_en;
        evt_en[serie_pkg::BIT_KEY_LIST_RDY-1] =
            key_list_ready_irq_en;
        evt_en[serie_pkg::BIT_RX_KEY_RDY-1] =
            receiver_key_ready_irq_en;
        evt_en[serie_pkg::BIT_AUTH_FAIL-1] =
            auth_failure_irq_en;
        evt_en[serie_pkg::BIT_AUTH_PASS-1] =
            auth_pass_irq_en;
    end

    // ==========================================================
    // Per-event gating
    generate
        for (genvar gi = 0; gi < NE; gi = gi + 1) begin : g_gate
            assign gated[gi] = flags[gi] & evt_en[gi];
        end
    endgenerate

    // ==========================================================
    // Global condition and status byte
    assign global_int = |gated;
    assign status = pack_status(flags, global_int);

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;

        // Status is read-only: only the enable byte takes writes
        if (wr_enable) begin
            s_d.enable = WDATA;
        end

        // Read data holds between reads
        if (RD_EN) begin
            s_d.rdata = read_value(ADDR, s_q.enable, status);
        end

        // Interrupt line lags the flags by one cycle
        s_d.irq = irq_master_en && global_int;
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q <= '{enable: serie_pkg::RESET_IRQ_ENABLE, rdata: '0,
                     irq: 1'h0};
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign RDATA = s_q.rdata;
    assign IRQ = s_q.irq;
endmodule

//--- tb/serie_top_assertions.sv
// Checker for the serie_top register port and IRQ line.
// Assumes strobes last one cycle, as the host model drives them.
module serie_chk (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic WR_EN,
    input wire logic [7:0] WDATA,
    input wire logic RD_EN,
    input wire logic [7:0] RDATA,
    input wire logic IRQ
);
    timeunit 1ns / 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_master_off: assert property (
        WR_EN && ADDR == 8'hC6 && !WDATA[0] |-> ##2 !IRQ) else $error("irq on");
    a_enables_off: assert property (
        WR_EN && ADDR == 8'hC6 && WDATA[7:1] == 7'h00 |-> ##2 !IRQ)
        else $error("irq without enables");
    a_enable_back: assert property (WR_EN && ADDR == 8'hC6 ##1 RD_EN &&
        ADDR == 8'hC6 |=> RDATA == $past(WDATA, 2)) else $error("enable lost");
    a_status_ro: assert property (WR_EN && ADDR == 8'hC6 ##1 WR_EN &&
        ADDR == 8'hC7 ##1 RD_EN && ADDR == 8'hC6 |=> RDATA == $past(WDATA, 3))
        else $error("status write took");
    a_global_bit: assert property (RD_EN && ADDR == 8'hC7 |=>
        RDATA[7:1] != 7'h00 || !RDATA[0]) else $error("global bit");
    a_unmapped: assert property (
        RD_EN && ADDR[7:1] != 7'h63 |=> RDATA == 8'h00) else $error("unmapped");
    a_rd_hold: assert property (
        !RD_EN |=> $stable(RDATA)) else $error("rdata moved");
    a_reset_quiet: assert property (
        $fell(RST) |-> !IRQ && RDATA == 8'h00) else $error("reset state");
endmodule
bind serie_top serie_chk u_chk (.CLK, .RST, .ADDR, .WR_EN, .WDATA, .RD_EN,
    .RDATA, .IRQ);

//--- tb/serie_host.sv
// Host model: drives one register strobe per CLK cycle.
// Assumes each call starts just after a CLK rise.
module serie_host (
    input wire logic CLK,
    input wire logic [7:0] RDATA,
    output logic [7:0] ADDR,
    output logic WR_EN,
    output logic [7:0] WDATA,
    output logic RD_EN
);
    timeunit 1ns / 1ns;
    initial {ADDR, WDATA, WR_EN, RD_EN} = 18'h0;
    // Strobes held until next call, so back-to-back works
    task automatic acc(input logic [1:0] k, input logic [7:0] a, d,
        output logic [7:0] q);
        {ADDR, WDATA, WR_EN, RD_EN} = {a, d, k};
        @(posedge CLK);
        #1 q = RDATA;
    endtask
endmodule

//--- tb/serializer_interrupt_enable_tb.sv
// Bench: enable and status registers and IRQ gating of serie_top.
// Assumes the host model drives the register port.
module serializer_interrupt_enable_tb;
    timeunit 1ns / 1ns;
    logic CLK = 1'h0, RST = 1'h1, IRQ, WR_EN, RD_EN;
    logic [7:0] ADDR, WDATA, RDATA, q;
    logic [7:1] ev = 7'h00;
    int fail_count = 0, compares = 0;
    always #4 CLK = ~CLK;
    serie_host host (.CLK, .RDATA, .ADDR, .WR_EN, .WDATA, .RD_EN);
    serie_top uut (.CLK, .RST, .ADDR, .WR_EN, .WDATA, .RD_EN, .RDATA, .IRQ,
        .INDIRECT_DONE(ev[7]), .RX_DETECT(ev[6]), .DOWNSTREAM_IRQ(ev[5]),
        .KEY_LIST_READY(ev[4]), .RX_KEY_READY(ev[3]), .AUTH_FAIL(ev[2]),
        .AUTH_PASS(ev[1]));
    task automatic chk(input logic [7:0] g, e);
        compares++;
        fail_count += int'(g !== e);
        if (g !== e) $display("BAD t=%0t got %h exp %h", $time, g, e);
    endtask
    task automatic rd(input logic [7:0] a, e);
        host.acc(2'h1, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic chk_irq(input logic g, e);
        compares++;
        fail_count += int'(g !== e);
        if (g !== e) $display("BAD t=%0t got %h exp %h", $time, g, e);
    endtask
    task automatic pulse(input logic [7:1] m, input logic e);
        host.acc(2'h0, 8'h00, 8'h00, q);
        ev = m;
        @(posedge CLK);
        #1 ev = 7'h00;
        @(posedge CLK);
        #1 chk_irq(IRQ, e);
    endtask
    task automatic results(input int late);
        fail_count += late;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial #20000 results(1);
    initial begin
        logic [7:0] m;
        repeat (4) @(posedge CLK);
        #1 RST = 1'h0;
        rd(8'hC6, 8'h00);
        host.acc(2'h2, 8'hC6, 8'h01, q);
        for (int i = 1; i < 8; i++) begin
            m = 8'h01 << i;
            host.acc(2'h2, 8'hC6, m | 8'h01, q);
            rd(8'hC6, m | 8'h01);
            pulse(~m[7:1], 1'h0);
            rd(8'hC7, ~m & 8'hFE);
            pulse(m[7:1], 1'h1);
            rd(8'hC7, m | 8'h01);
        end
        $display("test event gating done");
        host.acc(2'h2, 8'hC6, 8'hFE, q);
        host.acc(2'h2, 8'hC7, 8'hFF, q);
        rd(8'hC6, 8'hFE);
        rd(8'hC7, 8'h00);
        pulse(7'h7F, 1'h0);
        ev = 7'h01;
        rd(8'hC7, 8'hFF);
        ev = 7'h00;
        rd(8'hC7, 8'h03);
        rd(8'h7A, 8'h00);
        $display("test master enable done");
        results(0);
    end
endmodule
